// ### dv/spg_periph_model.sv
`timescale 1ns/1ps
`default_nettype none

module spg_periph_model
    import spg_pkg::*;
(
    input  wire logic clk,
    input  wire logic active,
    output spg_req_s  req
);
    // new activity mix each cycle; temp trip held low, it would restart the core mid-test
    always @(posedge clk) begin
        req <= active ? spg_req_s'(8'($urandom) & 8'hfe) : spg_req_s'(8'h00);
    end
endmodule // spg_periph_model

`default_nettype wire

// ### dv/spg_stop_ctrl_chk.sv
`timescale 1ns/1ps
`default_nettype none

module spg_stop_ctrl_chk
    import spg_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      rst_n,
    input  wire spg_req_s  req,
    input  wire spg_gate_s gate_r,
    input  wire spg_pwr_s  pwr_r,
    input  wire logic      pins_hiz_r,
    input  wire logic      periph_rst_r,
    input  wire logic      illegal_rst_r
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence wake_pulse_s;
        periph_rst_r[*4] ##1 !periph_rst_r;
    endsequence

    AST_WAKE_TMR_ON: assert property (gate_r.wake_tmr)
        else $error("wakeup unit clock gated");
    AST_FAST_OFF: assert property (pins_hiz_r |-> !gate_r.fast_osc)
        else $error("fast osc running in deep stop");
    AST_STOP_GATES: assert property (!gate_r.fast_osc |-> !gate_r.periph && !gate_r.tpm)
        else $error("peripheral clock running in stop");
    AST_DEEP_REG: assert property (pins_hiz_r |-> !pwr_r.reg_full && !gate_r.adc)
        else $error("regulator or converter on in deep stop");
    AST_WAKE_RST: assert property ($rose(periph_rst_r) |-> wake_pulse_s)
        else $error("wake reset length wrong");
    AST_ILL_PULSE: assert property (illegal_rst_r |-> gate_r.fast_osc ##1 !illegal_rst_r)
        else $error("illegal reset not a single pulse in run");
    AST_MID_OSC: assert property (!gate_r.fast_osc && gate_r.mid_osc
        |-> $past(req.meas_press || req.meas_accel || req.rf_busy))
        else $error("mid osc on without activity");
    AST_P_CELL: assert property (pwr_r.p_cell |-> $past(req.meas_press))
        else $error("pressure cell on without measurement");
    AST_RF_CHAIN: assert property (!gate_r.fast_osc
        |-> pwr_r.rf_chain == $past(req.rf_busy || req.rf_send))
        else $error("rf chain power wrong in stop");
    AST_LF_DET: assert property (!gate_r.fast_osc
        |-> pwr_r.lf_det == $past(req.lf_sample))
        else $error("lf detector power wrong in stop");
endmodule // spg_stop_ctrl_chk

bind spg_stop_ctrl spg_stop_ctrl_chk chk_u (
    .clk(clk), .rst_n(rst_n), .req(req), .gate_r(gate_r), .pwr_r(pwr_r),
    .pins_hiz_r(pins_hiz_r), .periph_rst_r(periph_rst_r), .illegal_rst_r(illegal_rst_r)
);

`default_nettype wire

// ### dv/spg_stop_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none

module spg_stop_ctrl_tb;
    import spg_pkg::*;
    logic       clk, rst_n, wr, rd, wake_req, act, hiz, prst, crst, ill;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, v, pd;
    logic [5:0] pi;
    spg_req_s   req;
    spg_gate_s  gate;
    spg_pwr_s   pwr;
    int         miscompares, comparisons, n, nprst, ncrst, nill, deep;
    int         exp_q[$];
    logic [7:0] cfg [4] = '{8'h11, 8'h13, 8'h15, 8'h21};

    spg_stop_ctrl dut_u (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .req(req), .wake_req(wake_req), .gate_r(gate), .pwr_r(pwr),
        .pins_hiz_r(hiz), .periph_rst_r(prst), .core_rst_r(crst), .illegal_rst_r(ill));
    spg_periph_model model_u (.clk(clk), .active(act), .req(req));

    always @(posedge clk) begin
        if (prst === 1'b1) nprst++;
        if (crst === 1'b1) ncrst++;
        if (ill === 1'b1) nill++;
    end

    // reference for measurement power: request seen at one edge, enable one edge later
    always @(posedge clk) begin
        if (rst_n !== 1'b1) begin
            exp_q.delete();
        end else begin
            if (exp_q.size() > 0)
                chk(8'({pwr.bandgap, pwr.p_cell, pwr.g_cell}), 8'(exp_q.pop_front()));
            exp_q.push_back(int'({req.meas_press | req.meas_accel | req.meas_volt,
                                  req.meas_press, req.meas_accel}));
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        rd <= 1'b1; addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic stop_test;
        $display("miscompares %0d comparisons %0d", miscompares, comparisons);
        if (miscompares == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial begin
        #(40 * 3000);
        miscompares++;
        stop_test();
    end

    initial begin
        rst_n = 1'b0; wr = 1'b0; rd = 1'b0; addr = 4'h0; wdata = 8'h00;
        wake_req = 1'b0; act = 1'b0; miscompares = 0; comparisons = 0;
        n = $urandom(23);
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(SPG_CTRL_ADDR, v); chk(v, SPG_CTRL_RST);
        rd_reg(4'h7, v); chk(v, 8'h00);
        chk(gate, 8'hff);
        pi = 6'($urandom);
        pd = 8'($urandom);
        wr_reg(SPG_PIDX_ADDR, {2'b00, pi});
        wr_reg(SPG_PARAM_ADDR, pd);
        @(posedge clk) rst_n <= 1'b0;
        @(posedge clk) rst_n <= 1'b1;
        wr_reg(SPG_PIDX_ADDR, {2'b00, pi});
        rd_reg(SPG_PARAM_ADDR, v); chk(v, pd);
        nill = 0;
        wr_reg(SPG_CMD_ADDR, 8'h01);
        repeat (4) @(posedge clk);
        chk(8'(nill), 8'h01);
        rd_reg(SPG_STATUS_ADDR, v); chk(v, 8'h00);
        act <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            deep = (cfg[i] == 8'h11);
            wr_reg(SPG_CTRL_ADDR, cfg[i]);
            rd_reg(SPG_CTRL_ADDR, v); chk(v, cfg[i]);
            wr_reg(SPG_CMD_ADDR, 8'h01);
            @(posedge clk);
            #1;
            chk(hiz, 8'(deep));
            chk({gate.periph, gate.tpm, gate.wake_tmr, gate.lf_rx, gate.fast_osc}, 8'h06);
            chk(pwr.temp_sens, 8'(cfg[i][5]));
            chk(gate.adc, 8'(!deep));
            chk(gate.dbg, 8'(cfg[i][2]));
            chk(pwr.reg_full, 8'(!deep));
            rd_reg(SPG_STATUS_ADDR, v); chk(v, deep ? 8'h09 : 8'h02);
            nprst = 0;
            ncrst = 0;
            if (i % 2) begin
                @(posedge clk) wake_req <= 1'b1;
                repeat (4) @(posedge clk);
                wake_req <= 1'b0;
            end else begin
                wr_reg(SPG_CMD_ADDR, 8'h02);
            end
            repeat (10) @(posedge clk);
            chk(8'(nprst), deep ? 8'(SPG_WAKE_RST_CYC) : 8'h00);
            chk(8'(ncrst), deep ? 8'(SPG_WAKE_RST_CYC) : 8'h00);
            chk(gate, 8'hff);
            rd_reg(SPG_STATUS_ADDR, v); chk(v, 8'h00);
        end
        stop_test();
    end
endmodule // spg_stop_ctrl_tb

`default_nettype wire

// ### hw/spg_param_store.sv
`timescale 1ns/1ps
`default_nettype none

// always-on parameter bytes: no reset term at all
module spg_param_store
    import spg_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    we,
    input  wire logic [SPG_PARAM_AW-1:0] addr,
    input  wire logic [7:0]              wdata,
    output logic      [7:0]              rdata
);

    logic [7:0] mem [SPG_PARAM_DEPTH];

    // contents survive every reset source
    always_ff @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
    end

    assign rdata = mem[addr];

endmodule // spg_param_store

`default_nettype wire

// ### hw/spg_pkg.sv
package spg_pkg;

    // register map on the plain software port (byte addresses)
    localparam logic [3:0] SPG_CTRL_ADDR    = 4'h0;
    localparam logic [3:0] SPG_CMD_ADDR     = 4'h1;
    localparam logic [3:0] SPG_STATUS_ADDR  = 4'h2;
    localparam logic [3:0] SPG_GATE_ADDR    = 4'h3;
    localparam logic [3:0] SPG_PWR_ADDR     = 4'h4;
    localparam logic [3:0] SPG_PARAM_ADDR   = 4'h5;
    localparam logic [3:0] SPG_PIDX_ADDR    = 4'h6;

    // control register bit positions
    localparam int SPG_CTRL_STOP_EN  = 0;
    localparam int SPG_CTRL_LV_STOP  = 1;
    localparam int SPG_CTRL_DBG_STOP = 2;
    localparam int SPG_CTRL_TRST_EN  = 3;
    localparam int SPG_CTRL_DEEP   = 4;
    localparam int SPG_CTRL_TSENS  = 5;
    localparam logic [7:0] SPG_CTRL_RST = 8'h00;

    // command register bit positions (write-one pulses)
    localparam int SPG_CMD_STOP    = 0;
    localparam int SPG_CMD_WAKE    = 1;

    localparam int SPG_PARAM_DEPTH = 64;
    localparam int SPG_PARAM_AW    = 6;

    // cycles the wake-reset pulse stands
    localparam int SPG_WAKE_RST_CYC = 4;

    typedef enum logic [1:0] {
        SPG_RUN,
        SPG_DEEP,
        SPG_REG,
        SPG_WAKE
    } spg_state_e;

    // peripheral activity requests coming in from the sensor, rf and lf blocks
    typedef struct packed {
        logic meas_press;
        logic meas_accel;
        logic meas_volt;
        logic rf_busy;
        logic rf_send;
        logic rf_direct;
        logic lf_sample;
        logic temp_trip;
    } spg_req_s;

    // clock enables per gated domain
    typedef struct packed {
        logic periph;
        logic tpm;
        logic adc;
        logic wake_tmr;
        logic lf_rx;
        logic dbg;
        logic fast_osc;
        logic mid_osc;
    } spg_gate_s;

    // power enables per analogue or rf domain
    typedef struct packed {
        logic reg_full;
        logic bandgap;
        logic p_cell;
        logic g_cell;
        logic temp_sens;
        logic temp_rst;
        logic rf_chain;
        logic lf_det;
    } spg_pwr_s;

endpackage : spg_pkg

// ### hw/spg_stop_ctrl.sv
// How it works
// - stop gates peripheral clocks except wakeup, lf
// - debug enable keeps debug clock in stop
// - deep stop forces pins high impedance
// - deep wake resets peripheral registers, loses ram
// - 64 parameter bytes survive every reset
// - periodic wakeup unit always clocked
// - mid oscillator on in stop only for pressure, accel, rf busy
// - fast oscillator off in every stop
// - converter runs and starts in regulated stop
// - converter registers reset after deep wake
// - lf detectors follow sampling selection in stop
// - bandgap on only when measurement needs it
// - timer stopped in stop, reset on deep wake
// - regulator standby only in deep stop
// - temp restart powered when enabled, restarts core
// - temperature sensor powered only on command
// - rf chain powered while sending or direct send
// - rf stays powered after sequence if send set
// - pressure and accel cells only while measuring
// - stop without enable forces illegal opcode reset
// - deep request with lvd or debug gives regulated
// - deep wake restarts core from reset vector
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none

module spg_stop_ctrl
    import spg_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [3:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    input  wire spg_req_s   req,
    input  wire logic       wake_req,
    output spg_gate_s       gate_r,
    output spg_pwr_s        pwr_r,
    output logic            pins_hiz_r,
    output logic            periph_rst_r,
    output logic            core_rst_r,
    output logic            illegal_rst_r
);

    logic [7:0]              ctrl_r;
    logic [SPG_PARAM_AW-1:0] pidx_r;
    logic [7:0]              param_rd;
    logic                    stop_cmd;
    logic                    wake_cmd;
    logic                    wake_any;
    logic                    param_we;
    logic                    reg_sel;
    logic                    temp_s1_r;
    logic                    temp_s2_r;
    logic                    wake_s1_r;
    logic                    wake_s2_r;
    logic [2:0]              wcnt_r;
    spg_state_e              state_r;
    spg_state_e              state_nxt;
    logic                    stop_nxt;
    logic                    reg_nxt;
    logic                    gate_periph_r;
    logic                    gate_tpm_r;
    logic                    gate_adc_r;
    logic                    gate_wtmr_r;
    logic                    gate_lf_r;
    logic                    gate_dbg_r;
    logic                    gate_fast_r;
    logic                    gate_mid_r;
    logic                    pwr_reg_r;
    logic                    pwr_bg_r;
    logic                    pwr_pcell_r;
    logic                    pwr_gcell_r;
    logic                    pwr_tsens_r;
    logic                    pwr_trst_r;
    logic                    pwr_rf_r;
    logic                    pwr_lfdet_r;

    function automatic logic sel_reg(input logic [7:0] c);
        sel_reg = c[SPG_CTRL_LV_STOP] | c[SPG_CTRL_DBG_STOP];
    endfunction

    assign stop_cmd = wr && (addr == SPG_CMD_ADDR) && wdata[SPG_CMD_STOP];
    assign wake_cmd = wr && (addr == SPG_CMD_ADDR) && wdata[SPG_CMD_WAKE];
    assign param_we = wr && (addr == SPG_PARAM_ADDR);
    assign reg_sel  = sel_reg(ctrl_r);

    // wake and trip arrive from the always-on slow domain
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wake_s1_r <= 1'b0;
            wake_s2_r <= 1'b0;
            temp_s1_r <= 1'b0;
            temp_s2_r <= 1'b0;
        end else begin
            wake_s1_r <= wake_req;
            wake_s2_r <= wake_s1_r;
            temp_s1_r <= req.temp_trip;
            temp_s2_r <= temp_s1_r;
        end
    end

    assign wake_any = wake_s2_r | wake_cmd;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_r <= SPG_CTRL_RST;
            pidx_r <= '0;
        end else if (wr) begin
            if (addr == SPG_CTRL_ADDR) begin
                ctrl_r <= wdata;
            end else if (addr == SPG_PIDX_ADDR) begin
                pidx_r <= wdata[SPG_PARAM_AW-1:0];
            end
        end
    end

    spg_param_store u_param (
        .clk   (clk),
        .we    (param_we),
        .addr  (pidx_r),
        .wdata (wdata),
        .rdata (param_rd)
    );

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            SPG_RUN: begin
                if (stop_cmd && ctrl_r[SPG_CTRL_STOP_EN]) begin
                    // a deep request falls back to regulated stop when low-voltage or debug stop is set
                    if (ctrl_r[SPG_CTRL_DEEP] && !reg_sel) begin
                        state_nxt = SPG_DEEP;
                    end else begin
                        state_nxt = SPG_REG;
                    end
                end
            end
            SPG_DEEP: begin
                if (wake_any) begin
                    state_nxt = SPG_WAKE;
                end
            end
            SPG_REG: begin
                if (wake_any) begin
                    state_nxt = SPG_RUN;
                end
            end
            SPG_WAKE: begin
                if (wcnt_r == 3'(SPG_WAKE_RST_CYC - 1)) begin
                    state_nxt = SPG_RUN;
                end
            end
            default: state_nxt = SPG_RUN;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r <= SPG_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || state_r != SPG_WAKE) begin
            wcnt_r <= '0;
        end else begin
            wcnt_r <= wcnt_r + 3'd1;
        end
    end

    // illegal stop: one-cycle reset request
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            illegal_rst_r <= 1'b0;
        end else begin
            illegal_rst_r <= (state_r == SPG_RUN) && stop_cmd
                             && !ctrl_r[SPG_CTRL_STOP_EN];
        end
    end

    // deep wake pulses peripheral and core reset; temp trip restarts core too when temp restart is enabled
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            periph_rst_r <= 1'b0;
            core_rst_r   <= 1'b0;
        end else begin
            periph_rst_r <= (state_nxt == SPG_WAKE);
            core_rst_r   <= (state_nxt == SPG_WAKE)
                            || (temp_s2_r && ctrl_r[SPG_CTRL_TRST_EN]);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pins_hiz_r <= 1'b0;
        end else begin
            pins_hiz_r <= (state_nxt == SPG_DEEP);
        end
    end

    // enables follow the state being entered, so they switch together with state_r
    assign stop_nxt = (state_nxt == SPG_DEEP) || (state_nxt == SPG_REG);
    assign reg_nxt  = (state_nxt == SPG_REG);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            gate_periph_r <= 1'b1;
        end else begin
            gate_periph_r <= !stop_nxt;
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            gate_tpm_r <= 1'b1;
        end else begin
            gate_tpm_r <= !stop_nxt;
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            gate_adc_r <= 1'b1;
        end else begin
            gate_adc_r <= !stop_nxt || reg_nxt;
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            gate_wtmr_r <= 1'b1;
        end else begin
            gate_wtmr_r <= 1'b1;
        end
    end
    // lf decoder keeps its clock so it can still wake the core
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            gate_lf_r <= 1'b1;
        end else begin
            gate_lf_r <= 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            gate_dbg_r <= 1'b1;
        end else begin
            gate_dbg_r <= !stop_nxt || ctrl_r[SPG_CTRL_DBG_STOP];
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            gate_fast_r <= 1'b1;
        end else begin
            gate_fast_r <= !stop_nxt;
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            gate_mid_r <= 1'b1;
        end else begin
            gate_mid_r <= !stop_nxt || req.meas_press || req.meas_accel || req.rf_busy;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pwr_reg_r <= 1'b0;
        end else begin
            pwr_reg_r <= !stop_nxt || reg_nxt;
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pwr_bg_r <= 1'b0;
        end else begin
            pwr_bg_r <= req.meas_press || req.meas_accel || req.meas_volt;
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pwr_pcell_r <= 1'b0;
        end else begin
            pwr_pcell_r <= req.meas_press;
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pwr_gcell_r <= 1'b0;
        end else begin
            pwr_gcell_r <= req.meas_accel;
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pwr_tsens_r <= 1'b0;
        end else begin
            pwr_tsens_r <= ctrl_r[SPG_CTRL_TSENS];
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pwr_trst_r <= 1'b0;
        end else begin
            pwr_trst_r <= !stop_nxt || ctrl_r[SPG_CTRL_TRST_EN];
        end
    end
    // send still set after a sequence keeps the chain up; direct mode implies send
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pwr_rf_r <= 1'b0;
        end else begin
            pwr_rf_r <= !stop_nxt || req.rf_busy || req.rf_send;
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pwr_lfdet_r <= 1'b0;
        end else begin
            pwr_lfdet_r <= !stop_nxt || req.lf_sample;
        end
    end

    assign gate_r = {gate_periph_r, gate_tpm_r, gate_adc_r, gate_wtmr_r,
                     gate_lf_r, gate_dbg_r, gate_fast_r, gate_mid_r};
    assign pwr_r  = {pwr_reg_r, pwr_bg_r, pwr_pcell_r, pwr_gcell_r,
                     pwr_tsens_r, pwr_trst_r, pwr_rf_r, pwr_lfdet_r};

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata <= '0;
        end else if (rd) begin
            if (addr == SPG_CTRL_ADDR) begin
                rdata <= ctrl_r;
            end else if (addr == SPG_STATUS_ADDR) begin
                rdata <= {4'h0, pins_hiz_r, periph_rst_r, state_r};
            end else if (addr == SPG_GATE_ADDR) begin
                rdata <= gate_r;
            end else if (addr == SPG_PWR_ADDR) begin
                rdata <= pwr_r;
            end else if (addr == SPG_PARAM_ADDR) begin
                rdata <= param_rd;
            end else if (addr == SPG_PIDX_ADDR) begin
                rdata <= {2'h0, pidx_r};
            end else begin
                rdata <= '0;
            end
        end else begin
            rdata <= '0;
        end
    end

endmodule // spg_stop_ctrl

`default_nettype wire
